/* File: core/fcsc_pkg.sv */
// constants shared by the nonvolatile memory command and status control block
package fcsc_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_DIVIDER    = 8'h00;
    localparam logic [7:0] OFF_CONFIG     = 8'h04;
    localparam logic [7:0] OFF_PROTECTION = 8'h08;
    localparam logic [7:0] OFF_STATUS     = 8'h0C;
    localparam logic [7:0] OFF_COMMAND    = 8'h10;
    localparam logic [7:0] OFF_ARRAY_WR   = 8'h14;
    localparam logic [7:0] OFF_SECURITY   = 8'h18;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_DIV_LOADED  = 7;
    localparam int BIT_KEY_WR_EN   = 5;
    localparam int BIT_PROT_DIS    = 0;
    localparam int BIT_CBEF        = 7;
    localparam int BIT_CCF         = 6;
    localparam int BIT_PVIOL       = 5;
    localparam int BIT_ACCERR      = 4;
    localparam int BIT_BLANK       = 2;
    localparam int BIT_PRESCALE    = 6;
    localparam int ARR_ADDR_LSB    = 0;
    localparam int ARR_DATA_LSB    = 16;
    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
    localparam logic [7:0] CMD_BYTE_PROG   = 8'h20;
    localparam logic [7:0] CMD_BURST_PROG  = 8'h25;
    localparam logic [7:0] CMD_PAGE_ERASE  = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE  = 8'h41;
    // ----------------------------------------------------------------
    // addresses, reset values, security
    // ----------------------------------------------------------------
    localparam logic [15:0] KEY_ADDR_LO     = 16'hFFB0;
    localparam logic [15:0] KEY_ADDR_HI     = 16'hFFB7;
    localparam logic [8:0]  PAGE_OFFSET_MAX = 9'h1FF;
    localparam logic [6:0]  FPS_RESET       = 7'h7F;
    localparam logic        PDIS_RESET      = 1'b1;
    localparam logic [1:0]  SEC_RESET       = 2'h0;
    localparam logic [1:0]  SEC_UNSECURED   = 2'h2;
    localparam logic [2:0]  PRESCALE_LAST   = 3'h7;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} fcsc_seq_type;
endpackage

/* File: core/fcsc_clkdiv.sv */
// divider that turns the bus clock into the array timing tick
`timescale 1ns/1ps
module fcsc_clkdiv (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       enable_in,
    input  wire logic       prescale_in,
    input  wire logic [5:0] div_in,
    output logic            tick_out
);
    import fcsc_pkg::*;

    typedef struct packed {
        logic [2:0] pre;
        logic [5:0] cnt;
        logic       tick;
    } fcsc_div_state_type;

    fcsc_div_state_type st;
    fcsc_div_state_type next_st;

    // ------------------------------------------------------------
    // tick = bus / ((div+1) or 8*(div+1))
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!enable_in) begin
            next_st.pre = 3'h0;
            next_st.cnt = 6'h00;
        end else if (!prescale_in || st.pre == PRESCALE_LAST) begin
            next_st.pre = 3'h0;
            if (st.cnt >= div_in) begin
                next_st.cnt  = 6'h00;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 6'h01;
            end
        end else begin
            next_st.pre = st.pre + 3'h1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_out = st.tick;
endmodule

/* File: core/fcsc_top.sv */
// command, protection and status control for the nonvolatile program memory
// How it works
// - key-enable 0: key-range writes start commands; 1: they are key writes
// - protection loads from nonvolatile copy after reset; always readable
// - with protection enabled, only a smaller boundary select is accepted
// - with protection disabled, protection writes change nothing
// - boundary select sets top of unprotected region; protected program/erase refused
// - protection bit 0 at 0 protects selected block, at 1 protects none
// - writing 1 to buffer-empty launches; launch clears it
// - only burst program commands may wait in the buffer
// - complete flag: buffer empty and idle; writes ignored
// - protected program/erase ignored, sets violation; write 1 clears
// - bad sequence, early program/erase, stop mid-command set access error
// - blank check sets blank flag if all erased; new launch clears it
// - codes 05 blank check, 20 byte program, 25 burst program
// - codes 40 page erase, 41 mass erase
// - any other code raises access error and does not run
// - program/erase disabled until divider written once; loaded flag reads back
// - passing blank check switches security code to unsecured
`timescale 1ns/1ps
module fcsc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic [31:0]            avs_readdata_out,
    output logic                   avs_waitrequest_out,
    input  wire logic              array_done_in,
    input  wire logic              array_blank_in,
    input  wire logic              stop_in,
    input  wire logic [7:0]        nonvolatile_protect_copy_in,
    input  wire logic [1:0]        nonvolatile_security_in,
    output logic                   array_req_out,
    output logic [7:0]             array_op_out,
    output logic [15:0]            array_addr_out,
    output logic [7:0]             array_data_out,
    output logic                   array_tick_out,
    output logic                   key_strobe_out,
    output logic [2:0]             key_index_out,
    output logic [7:0]             key_data_out,
    output logic [1:0]             security_state_code_out
);
    import fcsc_pkg::*;

    typedef struct packed {
        logic         waitreq;
        logic [31:0]  rdata;
        logic         boot_done;
        logic         div_loaded;
        logic [6:0]   div_val;
        logic         key_write_enable;
        logic [6:0]   protect_boundary_select;
        logic         pdis;
        logic         cbef;
        logic         ccf;
        logic         pviol;
        logic         accerr;
        logic         blank;
        logic         busy;
        fcsc_seq_type seq;
        logic [7:0]   buf_cmd;
        logic [15:0]  buf_addr;
        logic [7:0]   buf_data;
        logic [7:0]   arr_op;
        logic [15:0]  arr_addr;
        logic [7:0]   arr_data;
        logic [1:0]   sec;
        logic         key_strobe;
        logic [2:0]   key_idx;
        logic [7:0]   key_data;
    } fcsc_main_state_type;

    fcsc_main_state_type st;
    fcsc_main_state_type next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic code_legal(input logic [7:0] c);
        code_legal = (c == CMD_BLANK_CHECK) || (c == CMD_BYTE_PROG) ||
                     (c == CMD_BURST_PROG) ||
                     (c == CMD_PAGE_ERASE) || (c == CMD_MASS_ERASE);
    endfunction

    function automatic logic is_protected(input logic [15:0] a, input logic [6:0] f,
                                          input logic dis);
        is_protected = !dis && (a > {f, PAGE_OFFSET_MAX});
    endfunction

    logic        access;
    logic        wr;
    logic [7:0]  idx;
    logic [7:0]  wd;
    logic [15:0] wa;
    logic        launch_try;
    logic        launch_bad_code;
    logic        launch_prot;
    logic        arr_done;
    logic        tick;

    assign access          = (avs_read_in || avs_write_in) && !st.waitreq;
    assign wr              = access && avs_write_in && avs_byteenable_in[0];
    assign idx             = 8'(avs_address_in);
    assign wd              = avs_writedata_in[7:0];
    assign wa              = avs_writedata_in[ARR_ADDR_LSB +: 16];
    assign launch_try      = wr && idx == OFF_STATUS && wd[BIT_CBEF] &&
                             st.seq == SEQ_CMD && st.cbef;
    assign launch_bad_code = !code_legal(st.buf_cmd);
    assign launch_prot     = st.buf_cmd == CMD_MASS_ERASE ?
                             (!st.pdis && st.protect_boundary_select != FPS_RESET) :
                             (st.buf_cmd != CMD_BLANK_CHECK &&
                              is_protected(st.buf_addr, st.protect_boundary_select, st.pdis));
    assign arr_done        = array_done_in && st.busy;

    fcsc_clkdiv u_clkdiv (
        .clk_in      (clk_in),
        .nrst_in     (nrst_in),
        .enable_in   (st.div_loaded),
        .prescale_in (st.div_val[BIT_PRESCALE]),
        .div_in      (st.div_val[5:0]),
        .tick_out    (tick)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.key_strobe = 1'b0;
        // bus: one wait cycle, read data captured with the wait release
        if (st.waitreq && (avs_read_in || avs_write_in)) begin
            next_st.waitreq = 1'b0;
            next_st.rdata   = 32'h0000_0000;
            if (avs_read_in) begin
                case (idx)
                    OFF_DIVIDER:    next_st.rdata[7:0] = {st.div_loaded, st.div_val};
                    OFF_CONFIG:     next_st.rdata[BIT_KEY_WR_EN] = st.key_write_enable;
                    OFF_PROTECTION: next_st.rdata[7:0] = {st.protect_boundary_select, st.pdis};
                    OFF_STATUS:     next_st.rdata[7:0] = {st.cbef, st.ccf, st.pviol,
                                                          st.accerr, 1'b0, st.blank, 2'h0};
                    OFF_COMMAND:    next_st.rdata[7:0] = st.buf_cmd;
                    OFF_SECURITY:   next_st.rdata[1:0] = st.sec;
                    default:        next_st.rdata = 32'h0000_0000;
                endcase
            end
        end else begin
            next_st.waitreq = 1'b1;
        end
        // load protection and security once reset is released
        if (!st.boot_done) begin
            next_st.boot_done = 1'b1;
            next_st.protect_boundary_select       = nonvolatile_protect_copy_in[7:1];
            next_st.pdis      = nonvolatile_protect_copy_in[BIT_PROT_DIS];
            next_st.sec       = nonvolatile_security_in;
        end
        // array finishes; a waiting burst moves into the array
        if (arr_done) begin
            if (st.arr_op == CMD_BLANK_CHECK) begin
                next_st.blank = array_blank_in;
                if (array_blank_in) begin
                    next_st.sec = SEC_UNSECURED;
                end
            end
            next_st.busy = 1'b0;
        end
        if (!st.cbef && (!st.busy || arr_done)) begin
            next_st.busy     = 1'b1;
            next_st.cbef     = 1'b1;
            next_st.arr_op   = st.buf_cmd;
            next_st.arr_addr = st.buf_addr;
            next_st.arr_data = st.buf_data;
        end
        // register writes
        if (wr) begin
            case (idx)
                OFF_DIVIDER: begin
                    if (!st.div_loaded) begin
                        next_st.div_loaded = 1'b1;
                        next_st.div_val    = wd[6:0];
                    end
                end
                OFF_CONFIG: next_st.key_write_enable = wd[BIT_KEY_WR_EN];
                OFF_PROTECTION: begin
                    // protection can only be tightened, never loosened by software
                    if (st.boot_done && !st.pdis && wd[7:1] < st.protect_boundary_select) begin
                        next_st.protect_boundary_select = wd[7:1];
                    end
                end
                OFF_ARRAY_WR: begin
                    if (st.key_write_enable && wa >= KEY_ADDR_LO && wa <= KEY_ADDR_HI) begin
                        next_st.key_strobe = 1'b1;
                        next_st.key_idx    = wa[2:0];
                        next_st.key_data   = avs_writedata_in[ARR_DATA_LSB +: 8];
                    end else if (st.seq == SEQ_IDLE && st.cbef) begin
                        next_st.seq      = SEQ_DATA;
                        next_st.buf_addr = wa;
                        next_st.buf_data = avs_writedata_in[ARR_DATA_LSB +: 8];
                    end else begin
                        next_st.accerr = 1'b1;
                        next_st.seq    = SEQ_IDLE;
                    end
                end
                OFF_COMMAND: begin
                    if (st.seq == SEQ_DATA) begin
                        next_st.buf_cmd = wd;
                        next_st.seq     = SEQ_CMD;
                    end else begin
                        next_st.accerr = 1'b1;
                        next_st.seq    = SEQ_IDLE;
                    end
                end
                OFF_STATUS: begin
                    // clears first so that a same-cycle set below wins
                    if (wd[BIT_PVIOL]) begin
                        next_st.pviol = 1'b0;
                    end
                    if (wd[BIT_ACCERR]) begin
                        next_st.accerr = 1'b0;
                    end
                    if (wd[BIT_CBEF]) begin
                        next_st.seq = SEQ_IDLE;
                        if (!launch_try) begin
                            next_st.accerr = 1'b1;
                        end else if (launch_bad_code) begin
                            next_st.accerr = 1'b1;
                        end else if (st.buf_cmd != CMD_BLANK_CHECK && !st.div_loaded) begin
                            next_st.accerr = 1'b1;
                        end else if (st.busy && !arr_done &&
                                     (st.buf_cmd != CMD_BURST_PROG ||
                                      st.arr_op != CMD_BURST_PROG)) begin
                            next_st.accerr = 1'b1;
                        end else if (launch_prot) begin
                            next_st.pviol = 1'b1;
                        end else begin
                            next_st.cbef  = 1'b0;
                            next_st.blank = 1'b0;
                        end
                    end
                end
                default: ;
            endcase
        end
        // entering stop aborts the command in flight
        if (stop_in && (st.busy || !st.cbef)) begin
            next_st.accerr = 1'b1;
            next_st.busy   = 1'b0;
            next_st.cbef   = 1'b1;
            next_st.seq    = SEQ_IDLE;
        end
        next_st.ccf = next_st.cbef && !next_st.busy;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st         <= '0;
            st.waitreq <= 1'b1;
            st.protect_boundary_select     <= FPS_RESET;
            st.pdis    <= PDIS_RESET;
            st.sec     <= SEC_RESET;
            st.seq     <= SEQ_IDLE;
            st.cbef    <= 1'b1;
            st.ccf     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata_out        = st.rdata;
    assign avs_waitrequest_out     = st.waitreq;
    assign array_req_out           = st.busy;
    assign array_op_out            = st.arr_op;
    assign array_addr_out          = st.arr_addr;
    assign array_data_out          = st.arr_data;
    assign array_tick_out          = tick;
    assign key_strobe_out          = st.key_strobe;
    assign key_index_out           = st.key_idx;
    assign key_data_out            = st.key_data;
    assign security_state_code_out = st.sec;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    property p_bus_answer;
        (avs_read_in || avs_write_in) && st.waitreq |=> !st.waitreq ##1 st.waitreq;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    property p_ccf;
        st.ccf == (st.cbef && !st.busy);
    endproperty
    a_ccf: assert property (p_ccf) else $error("complete flag wrong");

    property p_prot_frozen;
        st.boot_done && st.pdis |=> $stable(st.protect_boundary_select) && st.pdis;
    endproperty
    a_prot_frozen: assert property (p_prot_frozen) else $error("protection moved");

    property p_prot_tighten;
        st.boot_done && $past(st.boot_done) && st.protect_boundary_select != $past(st.protect_boundary_select) |->
            st.protect_boundary_select < $past(st.protect_boundary_select);
    endproperty
    a_prot_tighten: assert property (p_prot_tighten) else $error("protection loosened");

    property p_illegal;
        launch_try && launch_bad_code |=> st.accerr && st.cbef && !$rose(st.busy);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal code ran");

    property p_violation;
        launch_try && !launch_bad_code && st.div_loaded && !st.busy && launch_prot
            |=> st.pviol && st.cbef ##1 !st.busy;
    endproperty
    a_violation: assert property (p_violation) else $error("protected op ran");

    property p_blank_sec;
        arr_done && st.arr_op == CMD_BLANK_CHECK && array_blank_in |=>
            st.blank && st.sec == SEC_UNSECURED;
    endproperty
    a_blank_sec: assert property (p_blank_sec) else $error("blank result lost");

    property p_div_once;
        st.div_loaded |=> st.div_loaded && $stable(st.div_val);
    endproperty
    a_div_once: assert property (p_div_once) else $error("divider rewritten");

    property p_key;
        wr && idx == OFF_ARRAY_WR && st.key_write_enable &&
            wa >= KEY_ADDR_LO && wa <= KEY_ADDR_HI |=> st.key_strobe && $stable(st.seq);
    endproperty
    a_key: assert property (p_key) else $error("key write lost");

    // a stop in the buffer-full cycle aborts instead, so accept the error there
    property p_launch;
        launch_try && !launch_bad_code && !launch_prot && !st.busy &&
            (st.div_loaded || st.buf_cmd == CMD_BLANK_CHECK) |=>
            !st.cbef ##1 (st.busy || st.accerr);
    endproperty
    a_launch: assert property (p_launch) else $error("launch did not reach array");

    c_launch: cover property (launch_try ##1 !st.cbef ##1 st.busy);
    c_blank:  cover property (arr_done && st.arr_op == CMD_BLANK_CHECK);
    c_burst:  cover property (st.busy && !st.cbef ##[1:200] st.busy && st.cbef);
endmodule

/* File: bench/test_fcsc_top.sv */
// register-level self-checking bench for the command and status control block
`timescale 1ns/1ps
module test_fcsc_top;
    import fcsc_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic        clk_in      = 1'b0;
    logic        nrst_in     = 1'b0;
    logic [7:0]  avs_address_in   = 8'h00;
    logic        avs_read_in      = 1'b0;
    logic        avs_write_in     = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        array_done_in    = 1'b0;
    logic        array_blank_in   = 1'b0;
    logic        stop_in          = 1'b0;
    logic [7:0]  nv_prot          = 8'h80;
    logic [1:0]  nv_sec           = 2'h1;
    logic        array_req_out;
    logic        array_tick_out;
    logic [7:0]  array_op_out;
    logic [15:0] array_addr_out;
    logic [7:0]  array_data_out;
    logic        key_strobe_out;
    logic [2:0]  key_index_out;
    logic [7:0]  key_data_out;
    logic [1:0]  security_state_code_out;
    int          mismatches = 0;
    int          checks     = 0;
    int          key_count  = 0;
    int          tick_count = 0;
    int          t0;
    int          i;
    logic [7:0]  codes [4] = '{CMD_BLANK_CHECK, CMD_BYTE_PROG, CMD_BURST_PROG, CMD_PAGE_ERASE};
    logic [15:0] addrs [4] = '{16'h1000, 16'h81FF, 16'h1010, 16'h1200};

    fcsc_top fcsc_top_inst (
        .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .array_done_in(array_done_in), .array_blank_in(array_blank_in), .stop_in(stop_in),
        .nonvolatile_protect_copy_in(nv_prot), .nonvolatile_security_in(nv_sec),
        .array_req_out(array_req_out), .array_op_out(array_op_out),
        .array_addr_out(array_addr_out), .array_data_out(array_data_out),
        .array_tick_out(array_tick_out), .key_strobe_out(key_strobe_out),
        .key_index_out(key_index_out),
        .key_data_out(key_data_out), .security_state_code_out(security_state_code_out)
    );

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    // pulses are one cycle wide, so count them rather than sample them
    always @(posedge clk_in) begin
        if (key_strobe_out === 1'b1) key_count <= key_count + 1;
        if (array_tick_out === 1'b1) tick_count <= tick_count + 1;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        if (mismatches == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        if (n == 50) begin
            mismatches++;
            complete_run();
        end
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask

    // full sequence, then let the op reach the array
    task automatic cmd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
        wr(OFF_ARRAY_WR, {8'h00, d, a});
        wr(OFF_COMMAND, {24'h0000_00, c});
        wr(OFF_STATUS, 32'h0000_0080);
        @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic done(input logic blank);
        @(posedge clk_in);
        array_done_in  <= 1'b1;
        array_blank_in <= blank;
        @(posedge clk_in);
        array_done_in  <= 1'b0;
        @(negedge clk_in);
    endtask

    task automatic refused(input logic [15:0] a, input logic [7:0] c, input logic [7:0] st);
        cmd(a, 8'h5A, c);
        check(array_req_out, 32'h0000_0000);
        rd_check(OFF_STATUS, {24'h0000_00, st});
        wr(OFF_STATUS, 32'h0000_0030);
        rd_check(OFF_STATUS, 32'h0000_00C0);
    endtask

    task automatic do_reset(input logic [7:0] p);
        nrst_in <= 1'b0;
        nv_prot <= p;
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(8'h80);
        rd_check(OFF_STATUS, 32'h0000_00C0);
        rd_check(OFF_PROTECTION, 32'h0000_0080);
        rd_check(OFF_SECURITY, 32'h0000_0001);
        rd_check(8'h1C, 32'h0000_0000);
        refused(16'h1000, CMD_BYTE_PROG, 8'hD0);
        rd_check(OFF_DIVIDER, 32'h0000_0000);
        check(tick_count, 32'h0000_0000);
        wr(OFF_DIVIDER, 32'h0000_0005);
        wr(OFF_DIVIDER, 32'h0000_003F);
        rd_check(OFF_DIVIDER, 32'h0000_0085);
        // divisor 5 gives one tick in every 6 bus cycles
        t0 = tick_count;
        repeat (60) @(posedge clk_in);
        check(tick_count - t0, 32'h0000_000A);
        for (i = 0; i < 4; i++) begin
            cmd(addrs[i], 8'h3C, codes[i]);
            check(array_req_out, 32'h0000_0001);
            check(array_op_out, codes[i]);
            check(array_addr_out, addrs[i]);
            check(array_data_out, 32'h0000_003C);
            rd_check(OFF_STATUS, 32'h0000_0080);
            done(1'b0);
            rd_check(OFF_STATUS, 32'h0000_00C0);
        end
        refused(16'h0000, CMD_MASS_ERASE, 8'hE0);
        refused(16'h8200, CMD_BYTE_PROG, 8'hE0);
        refused(16'h1000, 8'h33, 8'hD0);
        wr(OFF_PROTECTION, 32'h0000_0060);
        rd_check(OFF_PROTECTION, 32'h0000_0060);
        wr(OFF_PROTECTION, 32'h0000_0070);
        rd_check(OFF_PROTECTION, 32'h0000_0060);
        refused(16'h6200, CMD_PAGE_ERASE, 8'hE0);
        cmd(16'h0000, 8'h00, CMD_BLANK_CHECK);
        done(1'b1);
        rd_check(OFF_STATUS, 32'h0000_00C4);
        check(security_state_code_out, SEC_UNSECURED);
        cmd(16'h1000, 8'h11, CMD_BYTE_PROG);
        rd_check(OFF_STATUS, 32'h0000_0080);
        done(1'b0);
        // second burst waits in the buffer behind the first
        cmd(16'h1000, 8'h01, CMD_BURST_PROG);
        cmd(16'h1001, 8'h02, CMD_BURST_PROG);
        rd_check(OFF_STATUS, 32'h0000_0000);
        done(1'b0);
        check(array_req_out, 32'h0000_0001);
        check(array_addr_out, 32'h0000_1001);
        check(array_data_out, 32'h0000_0002);
        rd_check(OFF_STATUS, 32'h0000_0080);
        done(1'b0);
        rd_check(OFF_STATUS, 32'h0000_00C0);
        cmd(16'h1000, 8'h22, CMD_BYTE_PROG);
        @(posedge clk_in);
        stop_in <= 1'b1;
        @(posedge clk_in);
        stop_in <= 1'b0;
        repeat (2) @(negedge clk_in);
        check(array_req_out, 32'h0000_0000);
        rd_check(OFF_STATUS, 32'h0000_00D0);
        wr(OFF_STATUS, 32'h0000_0010);
        wr(OFF_CONFIG, 32'h0000_0020);
        rd_check(OFF_CONFIG, 32'h0000_0020);
        wr(OFF_ARRAY_WR, 32'h00A5_FFB3);
        repeat (2) @(negedge clk_in);
        check(key_count, 32'h0000_0001);
        check(key_index_out, 32'h0000_0003);
        check(key_data_out, 32'h0000_00A5);
        rd_check(OFF_STATUS, 32'h0000_00C0);
        wr(OFF_CONFIG, 32'h0000_0000);
        refused(16'hFFB3, CMD_BYTE_PROG, 8'hE0);
        check(key_count, 32'h0000_0001);
        cmd(16'h1000, 8'h00, 8'hFF);
        @(posedge clk_in);
        do_reset(8'hFF);
        rd_check(OFF_STATUS, 32'h0000_00C0);
        wr(OFF_PROTECTION, 32'h0000_0000);
        rd_check(OFF_PROTECTION, 32'h0000_00FF);
        complete_run();
    end
endmodule
